// >>> verilog/cfp_pkg.sv
package cfp_pkg;
  localparam logic [7:0] OPC_WALK = 8'h00;
  localparam logic [7:0] OPC_FLAGS_TO_A = 8'h07;
  localparam logic [7:0] OPC_ZCMP_A = 8'h4D;
  localparam logic [7:0] OPC_ZCMP_B = 8'h5D;
  localparam logic [7:0] OPC_ZCMP_EXT = 8'h7D;
  localparam logic [7:0] OPC_ZCMP_IDX = 8'h6D;
  localparam logic [7:0] OPC_PREBYTE_Y = 8'h18;
  localparam logic [7:0] OPC_STACK_TO_X = 8'h30;
  localparam logic [15:0] DUMMY_ADDR = 16'hFFFF;
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [15:0] RESET_SP = 16'h0000;
  localparam logic [15:0] RESET_INDEX = 16'h0000;
  localparam logic [7:0] RESET_ACC = 8'h00;
  localparam logic [7:0] RESET_FLAGS = 8'h00;
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_V = 1;
  localparam int FLAG_C = 0;
  localparam logic [1:0] WALK_UP_STEPS = 2'h2;
  localparam logic TAIL_DUMMIES_M1 = 1'b1;
  typedef enum logic [3:0] {
    CFP_FETCH, CFP_OPND1, CFP_PAGE2, CFP_OFFS_Y, CFP_EXT_LO,
    CFP_PRE_DUMMY, CFP_OPERAND, CFP_TAIL, CFP_SP_READ, CFP_WALK
  } cfp_state_t;
endpackage

// >>> verilog/cfp_core.sv
`timescale 1ns/1ps
module cfp_core
  import cfp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic test_mode,
  input wire logic [7:0] mem_rdata,
  input wire logic preset_en,
  input wire logic [7:0] preset_acc_a,
  input wire logic [7:0] preset_acc_b,
  input wire logic [15:0] preset_x,
  input wire logic [15:0] preset_y,
  input wire logic [15:0] preset_sp,
  input wire logic [7:0] preset_flags,
  output logic [15:0] mem_addr,
  output logic mem_rw,
  output logic [7:0] mem_wdata,
  output logic illegal_op,
  output logic walk_active,
  output logic [15:0] prog_counter,
  output logic [7:0] accumulator_a,
  output logic [7:0] accumulator_b,
  output logic [15:0] index_reg_x,
  output logic [15:0] index_reg_y,
  output logic [15:0] stack_ptr,
  output logic [7:0] flag_register
);
  cfp_state_t state_r, state_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [7:0] op_r, op_nxt;
  logic [7:0] hi_r, hi_nxt;
  logic [7:0] off_r, off_nxt;
  logic use_y_r, use_y_nxt;
  logic tail_r, tail_nxt;
  logic [1:0] walk_cnt_r, walk_cnt_nxt;
  logic illegal_r, illegal_nxt;
  logic walk_r;
  logic rw_r;
  logic [7:0] wdata_r;
  logic tm_meta_r, tm_sync_r;
  logic [7:0] acc_a_r, acc_b_r, flags_r;
  logic [15:0] x_r, y_r, sp_r;
  logic [7:0] tested;
  logic do_flags_to_a, do_zcmp, do_stack_to_x;

  // test mode is a pin: two flops before anything looks at it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tm_meta_r <= 1'b0;
      tm_sync_r <= 1'b0;
    end else begin
      tm_meta_r <= test_mode;
      tm_sync_r <= tm_meta_r;
    end
  end

  // memory answers within the cycle its address is presented
  always_comb begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    pc_nxt = pc_r;
    op_nxt = op_r;
    hi_nxt = hi_r;
    off_nxt = off_r;
    use_y_nxt = use_y_r;
    tail_nxt = tail_r;
    walk_cnt_nxt = walk_cnt_r;
    illegal_nxt = 1'b0;
    do_flags_to_a = 1'b0;
    do_zcmp = 1'b0;
    do_stack_to_x = 1'b0;
    tested = mem_rdata;
    unique case (state_r)
      CFP_FETCH: begin
        op_nxt = mem_rdata;
        pc_nxt = pc_r + 16'h0001;
        addr_nxt = pc_r + 16'h0001;
        walk_cnt_nxt = 2'h0;
        if (mem_rdata == OPC_WALK && tm_sync_r) begin
          state_nxt = CFP_WALK;
        end else begin
          state_nxt = CFP_OPND1;
        end
      end
      CFP_OPND1: begin
        unique case (op_r)
          OPC_FLAGS_TO_A: begin
            do_flags_to_a = 1'b1;
            addr_nxt = pc_r;
            state_nxt = CFP_FETCH;
          end
          OPC_ZCMP_A: begin
            do_zcmp = 1'b1;
            tested = acc_a_r;
            addr_nxt = pc_r;
            state_nxt = CFP_FETCH;
          end
          OPC_ZCMP_B: begin
            do_zcmp = 1'b1;
            tested = acc_b_r;
            addr_nxt = pc_r;
            state_nxt = CFP_FETCH;
          end
          OPC_ZCMP_EXT: begin
            hi_nxt = mem_rdata;
            pc_nxt = pc_r + 16'h0001;
            addr_nxt = pc_r + 16'h0001;
            state_nxt = CFP_EXT_LO;
          end
          OPC_ZCMP_IDX: begin
            off_nxt = mem_rdata;
            use_y_nxt = 1'b0;
            pc_nxt = pc_r + 16'h0001;
            addr_nxt = DUMMY_ADDR;
            state_nxt = CFP_PRE_DUMMY;
          end
          OPC_PREBYTE_Y: begin
            // the second byte of the pair is on the bus in this cycle
            pc_nxt = pc_r + 16'h0001;
            addr_nxt = pc_r + 16'h0001;
            if (mem_rdata == OPC_ZCMP_IDX) begin
              state_nxt = CFP_OFFS_Y;
            end else begin
              state_nxt = CFP_PAGE2;
            end
          end
          OPC_STACK_TO_X: begin
            addr_nxt = sp_r;
            state_nxt = CFP_SP_READ;
          end
          default: begin
            // walk opcode without test mode lands here as illegal
            illegal_nxt = 1'b1;
            addr_nxt = pc_r;
            state_nxt = CFP_FETCH;
          end
        endcase
      end
      CFP_PAGE2: begin
        // unknown second byte after the prebyte: flag it and refetch
        illegal_nxt = 1'b1;
        addr_nxt = pc_r;
        state_nxt = CFP_FETCH;
      end
      CFP_OFFS_Y: begin
        off_nxt = mem_rdata;
        use_y_nxt = 1'b1;
        pc_nxt = pc_r + 16'h0001;
        addr_nxt = DUMMY_ADDR;
        state_nxt = CFP_PRE_DUMMY;
      end
      CFP_EXT_LO: begin
        pc_nxt = pc_r + 16'h0001;
        addr_nxt = {hi_r, mem_rdata};
        state_nxt = CFP_OPERAND;
      end
      CFP_PRE_DUMMY: begin
        // offset is unsigned, zero extended
        addr_nxt = (use_y_r ? y_r : x_r) + {8'h00, off_r};
        state_nxt = CFP_OPERAND;
      end
      CFP_OPERAND: begin
        do_zcmp = 1'b1;
        addr_nxt = DUMMY_ADDR;
        tail_nxt = TAIL_DUMMIES_M1;
        state_nxt = CFP_TAIL;
      end
      CFP_TAIL: begin
        if (tail_r) begin
          tail_nxt = 1'b0;
          addr_nxt = DUMMY_ADDR;
        end else begin
          addr_nxt = pc_r;
          state_nxt = CFP_FETCH;
        end
      end
      CFP_SP_READ: begin
        do_stack_to_x = 1'b1;
        addr_nxt = pc_r;
        state_nxt = CFP_FETCH;
      end
      CFP_WALK: begin
        // no exit here: only rst leaves this state
        if (walk_cnt_r == WALK_UP_STEPS) begin
          addr_nxt = addr_r - 16'h0001;
        end else begin
          addr_nxt = addr_r + 16'h0001;
          walk_cnt_nxt = walk_cnt_r + 2'h1;
        end
        pc_nxt = addr_nxt;
        state_nxt = CFP_WALK;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= CFP_FETCH;
      tail_r <= 1'b0;
      walk_cnt_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      tail_r <= tail_nxt;
      walk_cnt_r <= walk_cnt_nxt;
    end
  end

  // walk flag kept as its own flop so the output is not a state decode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      walk_r <= 1'b0;
    end else begin
      walk_r <= (state_nxt == CFP_WALK);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      illegal_r <= 1'b0;
    end else begin
      illegal_r <= illegal_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addr_r <= RESET_PC;
      pc_r <= RESET_PC;
    end else begin
      addr_r <= addr_nxt;
      pc_r <= pc_nxt;
    end
  end

  // operand latches only matter inside one instruction
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      op_r <= 8'h00;
      hi_r <= 8'h00;
      off_r <= 8'h00;
      use_y_r <= 1'b0;
    end else begin
      op_r <= op_nxt;
      hi_r <= hi_nxt;
      off_r <= off_nxt;
      use_y_r <= use_y_nxt;
    end
  end

  // nothing here ever writes, but the bus pins still come from flops
  // so a later write path only has to change their next values
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rw_r <= 1'b1;
      wdata_r <= 8'h00;
    end else begin
      rw_r <= 1'b1;
      wdata_r <= 8'h00;
    end
  end

  // preload wins over execution; use it only while the core is idle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_a_r <= RESET_ACC;
      acc_b_r <= RESET_ACC;
    end else if (preset_en) begin
      acc_a_r <= preset_acc_a;
      acc_b_r <= preset_acc_b;
    end else if (do_flags_to_a) begin
      acc_a_r <= flags_r;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flags_r <= RESET_FLAGS;
    end else if (preset_en) begin
      flags_r <= preset_flags;
    end else if (do_zcmp) begin
      flags_r[FLAG_N] <= tested[7];
      flags_r[FLAG_Z] <= (tested == 8'h00);
      flags_r[FLAG_V] <= 1'b0;
      flags_r[FLAG_C] <= 1'b0;
    end
  end

  // sp and y are only ever read by these instructions
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      x_r <= RESET_INDEX;
      y_r <= RESET_INDEX;
      sp_r <= RESET_SP;
    end else if (preset_en) begin
      x_r <= preset_x;
      y_r <= preset_y;
      sp_r <= preset_sp;
    end else if (do_stack_to_x) begin
      x_r <= sp_r + 16'h0001;
    end
  end

  always_comb begin
    mem_addr = addr_r;
    mem_rw = rw_r;
    mem_wdata = wdata_r;
    illegal_op = illegal_r;
    walk_active = walk_r;
    prog_counter = pc_r;
    accumulator_a = acc_a_r;
    accumulator_b = acc_b_r;
    index_reg_x = x_r;
    index_reg_y = y_r;
    stack_ptr = sp_r;
    flag_register = flags_r;
  end
endmodule

// >>> verification/cfp_core_assertions.sv
`timescale 1ns/1ps
module cfp_core_assertions
  import cfp_pkg::*;
(
  input logic ref_clk,
  input logic rst,
  input logic preset_en,
  input logic [15:0] mem_addr,
  input logic [7:0] mem_rdata,
  input logic walk_active,
  input logic [15:0] prog_counter,
  input logic [7:0] accumulator_a,
  input logic [15:0] index_reg_x,
  input logic [15:0] stack_ptr,
  input logic [7:0] flag_register
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_up;
    mem_addr == $past(mem_addr) + 16'h1;
  endsequence
  property p_up;
    $rose(walk_active) |-> s_up ##1 s_up ##1 s_up;
  endproperty
  a_up: assert property (p_up) else $error("walk climb wrong");
  property p_down;
    walk_active && $past(walk_active, 3) |->
      mem_addr == $past(mem_addr) - 16'h1;
  endproperty
  a_down: assert property (p_down) else $error("walk descent wrong");
  property p_hold;
    walk_active |=> walk_active;
  endproperty
  a_hold: assert property (p_hold) else $error("walk ended");
  property p_pc;
    walk_active |-> prog_counter == mem_addr;
  endproperty
  a_pc: assert property (p_pc) else $error("walk pc off bus");
  property p_flags;
    !$past(preset_en) && $changed(flag_register) |->
      flag_register[1:0] == 2'h0 &&
      flag_register[7:4] == $past(flag_register[7:4]);
  endproperty
  a_flags: assert property (p_flags) else $error("flag update wrong");
  property p_sp;
    $changed(stack_ptr) |-> $past(preset_en);
  endproperty
  a_sp: assert property (p_sp) else $error("stack pointer moved");
  // X may only change right after the read at the stack address
  property p_x;
    !$past(preset_en) && $changed(index_reg_x) |->
      index_reg_x == stack_ptr + 16'h1 && $past(mem_addr) == stack_ptr;
  endproperty
  a_x: assert property (p_x) else $error("index load wrong");
  property p_acc;
    !$past(preset_en) && $changed(accumulator_a) |->
      accumulator_a == flag_register;
  endproperty
  a_acc: assert property (p_acc) else $error("acc a load wrong");
  // operand cycle followed by the two trailing dummy reads
  sequence s_operand_tail;
    mem_addr != DUMMY_ADDR ##1 mem_addr == DUMMY_ADDR ##1
      mem_addr == DUMMY_ADDR;
  endsequence
  property p_neg;
    s_operand_tail |->
      $past(flag_register[FLAG_N]) == $past(mem_rdata[7], 2);
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");
  property p_zero;
    s_operand_tail |->
      $past(flag_register[FLAG_Z]) == ($past(mem_rdata, 2) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
endmodule

// >>> verification/cfp_mem_model.sv
`timescale 1ns/1ps
module cfp_mem_model (
  input logic [15:0] mem_addr,
  output logic [7:0] mem_rdata
);
  // no wait states: data must settle in the cycle the address shows
  logic [7:0] mem [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'(~i);
    end
  end
  assign mem_rdata = mem[mem_addr];
endmodule

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
  import cfp_pkg::*;
  logic ref_clk, rst, test_mode, preset_en, mem_rw, illegal_op, walk_active;
  logic [7:0] mem_rdata, mem_wdata, preset_acc_a, preset_acc_b, preset_flags;
  logic [7:0] accumulator_a, accumulator_b, flag_register, off, dy;
  logic [15:0] preset_x, preset_y, preset_sp, mem_addr, prog_counter;
  logic [15:0] index_reg_x, index_reg_y, stack_ptr;
  logic [15:0] exp_q[$];
  logic [7:0] prog[13];
  int n_mismatch = 0;
  int check_count = 0;
  cfp_core u_cfp_core (.ref_clk, .rst, .test_mode, .mem_rdata, .preset_en,
    .preset_acc_a, .preset_acc_b, .preset_x, .preset_y, .preset_sp,
    .preset_flags, .mem_addr, .mem_rw, .mem_wdata, .illegal_op, .walk_active,
    .prog_counter, .accumulator_a, .accumulator_b, .index_reg_x, .index_reg_y,
    .stack_ptr, .flag_register);
  cfp_mem_model u_cfp_mem_model (.mem_addr, .mem_rdata);
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    if (!rst && exp_q.size() > 0) begin
      check("mem_addr", mem_addr, exp_q.pop_front());
      check("mem_rw", mem_rw, 16'h0001);
      check("mem_wdata", mem_wdata, 16'h0000);
    end
  end
  task automatic run();
    @(negedge ref_clk);
    rst = 1'b0;
    preset_en = 1'b1;
    @(negedge ref_clk);
    preset_en = 1'b0;
    for (int k = 0; k < 60 && exp_q.size() > 0; k++) @(negedge ref_clk);
    if (exp_q.size() > 0) begin
      n_mismatch++;
      finish_test();
    end
  endtask
  initial begin
    rst = 1'b1;
    test_mode = 1'b0;
    preset_en = 1'b0;
    {preset_acc_a, preset_acc_b, preset_flags} = 24'h0;
    {preset_x, preset_y, preset_sp} = 48'h0;
    void'($urandom(32'hf2a3));
    repeat (8) @(negedge ref_clk);
    for (int it = 0; it < 3; it++) begin
      {preset_acc_a, preset_acc_b, preset_flags, off, dy} =
        40'({$urandom, $urandom});
      if (it == 0) dy = 8'h00;
      preset_x = {4'h1, 12'($urandom)};
      preset_y = {4'h2, 12'($urandom)};
      preset_sp = {4'h3, 12'($urandom)};
      prog = '{8'h07, 8'h4D, 8'h5D, 8'h7D, 8'h40, 8'h00, 8'h6D, off,
        8'h18, 8'h6D, off, 8'h30, 8'h00};
      foreach (prog[i]) u_cfp_mem_model.mem[i] = prog[i];
      u_cfp_mem_model.mem[16'h4000] = preset_acc_a;
      u_cfp_mem_model.mem[preset_x + off] = ~dy;
      u_cfp_mem_model.mem[preset_y + off] = dy;
      exp_q = {16'h0, 16'h1, 16'h1, 16'h2, 16'h2, 16'h3, 16'h3, 16'h4,
        16'h5, 16'h4000, 16'hFFFF, 16'hFFFF, 16'h6, 16'h7, 16'hFFFF,
        preset_x + off, 16'hFFFF, 16'hFFFF, 16'h8, 16'h9, 16'hA, 16'hFFFF,
        preset_y + off, 16'hFFFF, 16'hFFFF, 16'hB, 16'hC, preset_sp,
        16'hC, 16'hD};
      run();
      check("illegal_op", illegal_op, 1'b1);
      check("acc_a", accumulator_a, preset_flags);
      check("acc_b", accumulator_b, preset_acc_b);
      check("sp", stack_ptr, preset_sp);
      check("iy", index_reg_y, preset_y);
      check("ix", index_reg_x, preset_sp + 16'h1);
      check("flags", flag_register,
        {preset_flags[7:4], dy[7], dy == 8'h00, 2'h0});
      $display("test %0d done", it);
      rst = 1'b1;
      repeat (8) @(negedge ref_clk);
    end
    // the sync flops clear in reset, so the walk opcode sits behind a
    // two-cycle instruction that gives test mode time to settle
    test_mode = 1'b1;
    u_cfp_mem_model.mem[0] = OPC_FLAGS_TO_A;
    u_cfp_mem_model.mem[1] = OPC_WALK;
    repeat (4) @(negedge ref_clk);
    exp_q = {16'h0, 16'h1, 16'h1, 16'h2, 16'h3, 16'h4, 16'h3, 16'h2,
      16'h1, 16'h0, 16'hFFFF};
    run();
    check("walk_active", walk_active, 1'b1);
    repeat (20) @(negedge ref_clk);
    check("walk_pc", prog_counter, 16'hFFEA);
    rst = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("walk_end", walk_active, 1'b0);
    $display("test walk done");
    finish_test();
  end
endmodule
bind cfp_core cfp_core_assertions u_cfp_core_assertions (.ref_clk, .rst,
  .preset_en, .mem_addr, .mem_rdata, .walk_active, .prog_counter,
  .accumulator_a,
  .index_reg_x, .stack_ptr, .flag_register);
